// ==== design/parallel_port_unit.sv ====
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module parallel_port_unit (
	input  wire logic                   core_clk,
	input  wire logic                   srst,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire pport_pkg::host_pins_type host_in,
	output pport_pkg::port_out_type     port_out
);
	// ==========================================
	// Configuration registers, buffers, flags and pointers
	logic [7:0]  ctrl_q;
	logic [7:0]  mode_q;
	logic [7:0]  port_address_high;
	logic [7:0]  port_address_low;
	logic [7:0]  output_pair2_low;
	logic [7:0]  output_pair2_high;
	logic [7:0]  in_buf_q [4];
	logic [3:0]  input_buffer_full_flag;
	logic [3:0]  output_buffer_empty_flag;
	logic        input_overflow_flag;
	logic        output_underflow_flag;
	logic        port_interrupt_flag;
	logic [1:0]  rd_ptr_q;
	logic [1:0]  wr_ptr_q;
	logic        buf_mode_prev_q;

	wire logic        port_enable_bit = ctrl_q[pport_pkg::en_pos];
	wire logic [1:0]  port_mode_field = mode_q[pport_pkg::mode_pos +: 2];
	wire logic [1:0]  increment_mode_field = mode_q[pport_pkg::incm_pos +: 2];
	wire logic [1:0]  interrupt_mode_field = mode_q[pport_pkg::irqm_pos +: 2];
	wire logic [1:0]  chip_select_config_field = ctrl_q[pport_pkg::cscf_pos +: 2];
	// Slave active only in legacy mode with the port on
	wire logic        slave_port = port_enable_bit &&
		(port_mode_field == pport_pkg::mode_legacy);
	wire logic        buf_mode = slave_port &&
		(increment_mode_field == pport_pkg::incm_buf);
	// Outgoing byte array; pair one doubles as the address register
	wire logic [7:0]  out_buf [4] = '{port_address_low, port_address_high,
		output_pair2_low, output_pair2_high};

	// ==========================================
	// Host strobe synchronisers, polarity applied after the second stage
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [7:0] dsync1_q;
	logic [7:0] dsync2_q;
	logic       wr_act_q;
	logic       rd_act_q;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync1_q  <= 3'h0;
			sync2_q  <= 3'h0;
			dsync1_q <= 8'h00;
			dsync2_q <= 8'h00;
		end else begin
			sync1_q  <= {host_in.cs, host_in.rd, host_in.wr};
			sync2_q  <= sync1_q;
			dsync1_q <= host_in.data;
			dsync2_q <= dsync1_q;
		end
	end
	// Inputs read high-true when the polarity bit is set
	wire logic cs_on = sync2_q[2] ~^ ctrl_q[pport_pkg::csp_pos];
	wire logic rd_on = (sync2_q[1] ~^ ctrl_q[pport_pkg::rdp_pos]) && cs_on;
	wire logic wr_on = (sync2_q[0] ~^ ctrl_q[pport_pkg::wrp_pos]) && cs_on;
	// Data is latched while the write is active; bus settles well before the end edge
	logic [7:0] wr_data_q;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_act_q  <= 1'b0;
			rd_act_q  <= 1'b0;
			wr_data_q <= 8'h00;
		end else begin
			wr_act_q <= wr_on && slave_port;
			rd_act_q <= rd_on && slave_port;
			if (wr_on && slave_port) begin
				wr_data_q <= dsync2_q;
			end
		end
	end
	// Each strobe counts once, at its trailing edge
	wire logic wr_end = wr_act_q && !(wr_on && slave_port);
	wire logic rd_end = rd_act_q && !(rd_on && slave_port);
	wire logic [1:0] wr_idx = buf_mode ? wr_ptr_q : 2'h0;
	wire logic [1:0] rd_idx = buf_mode ? rd_ptr_q : 2'h0;
	wire logic wr_ovf = wr_end && input_buffer_full_flag[wr_idx] && buf_mode;
	wire logic rd_unf = rd_end && output_buffer_empty_flag[rd_idx];

	// ==========================================
	// APB decode
	wire logic        setup_wr = psel && !penable && pwrite;
	wire logic        acc     = psel && penable;
	wire logic        bus_wr  = acc && pwrite;
	wire logic        bus_rd  = acc && !pwrite;
	logic [31:0]      rd_mux;
	logic             known;

	// ==========================================
	// Buffer pointers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_ptr_q        <= 2'h0;
			wr_ptr_q        <= 2'h0;
			buf_mode_prev_q <= 1'b0;
		end else begin
			buf_mode_prev_q <= buf_mode;
			if (!port_enable_bit || (buf_mode && !buf_mode_prev_q)) begin
				rd_ptr_q <= 2'h0;
				wr_ptr_q <= 2'h0;
			end else if (buf_mode) begin
				if (rd_end) begin
					rd_ptr_q <= rd_ptr_q + 2'h1;
				end
				if (wr_end) begin
					wr_ptr_q <= wr_ptr_q + 2'h1;
				end
			end
		end
	end

	// ==========================================
	// Configuration and outgoing data written by software
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl_q            <= 8'h00;
			mode_q            <= 8'h00;
			port_address_high <= 8'h00;
			port_address_low  <= 8'h00;
			output_pair2_low  <= 8'h00;
			output_pair2_high <= 8'h00;
		end else if (bus_wr) begin
			case (paddr)
				pport_pkg::ctrl_addr:    ctrl_q <= pwdata[7:0];
				pport_pkg::mode_addr:    mode_q <= pwdata[7:0];
				pport_pkg::addr_hi_addr: port_address_high <= pwdata[7:0];
				pport_pkg::addr_lo_addr: port_address_low  <= pwdata[7:0];
				pport_pkg::out2_addr: begin
					output_pair2_low  <= pwdata[7:0];
					output_pair2_high <= pwdata[15:8];
				end
				default: ;
			endcase
		end
	end

	// ==========================================
	// Output empty flags: host read sets, software write clears
	always_ff @(posedge core_clk) begin
		if (srst) begin
			output_buffer_empty_flag <= pport_pkg::obe_reset;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (rd_end && rd_idx == 2'(i)) begin
					output_buffer_empty_flag[i] <= 1'b1;
				end else if (bus_wr && paddr == pport_pkg::addr_lo_addr && i == 0) begin
					output_buffer_empty_flag[i] <= 1'b0;
				end else if (bus_wr && paddr == pport_pkg::addr_hi_addr && i == 1) begin
					output_buffer_empty_flag[i] <= 1'b0;
				end else if (bus_wr && paddr == pport_pkg::out2_addr && i >= 2) begin
					output_buffer_empty_flag[i] <= 1'b0;
				end
			end
		end
	end

	// ==========================================
	// Input buffers and full flags; host set wins over software clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			input_buffer_full_flag <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				in_buf_q[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr_end && wr_idx == 2'(i) && !wr_ovf) begin
					in_buf_q[i]               <= wr_data_q;
					input_buffer_full_flag[i] <= 1'b1;
				end else if (bus_rd && pready && ((paddr == pport_pkg::in1_addr && i < 2) ||
						(paddr == pport_pkg::in2_addr && i >= 2))) begin
					input_buffer_full_flag[i] <= 1'b0;
				end
			end
		end
	end

	// ==========================================
	// Sticky error and interrupt flags, write one to clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			input_overflow_flag   <= 1'b0;
			output_underflow_flag <= 1'b0;
			port_interrupt_flag   <= 1'b0;
		end else begin
			if (wr_ovf) begin
				input_overflow_flag <= 1'b1;
			end else if (bus_wr && paddr == pport_pkg::stat_addr && pwdata[pport_pkg::ovf_pos]) begin
				input_overflow_flag <= 1'b0;
			end
			if (rd_unf) begin
				output_underflow_flag <= 1'b1;
			end else if (bus_wr && paddr == pport_pkg::stat_addr && pwdata[pport_pkg::unf_pos]) begin
				output_underflow_flag <= 1'b0;
			end
			if ((!buf_mode && wr_end) ||
					(buf_mode && interrupt_mode_field == pport_pkg::irq_every && (rd_end || wr_end)) ||
					(buf_mode && interrupt_mode_field == pport_pkg::irq_fourth &&
					((rd_end && rd_idx == 2'h3) || (wr_end && wr_idx == 2'h3)))) begin
				port_interrupt_flag <= 1'b1;
			end else if (bus_wr && paddr == pport_pkg::flag_addr && pwdata[0]) begin
				port_interrupt_flag <= 1'b0;
			end
		end
	end

	// ==========================================
	// Pins: data driven while a read is selected; chip selects from the address byte
	always_ff @(posedge core_clk) begin
		if (srst) begin
			port_out <= '0;
		end else begin
			port_out.data    <= out_buf[rd_idx];
			port_out.data_oe <= {8{rd_on && slave_port}};
			port_out.cs_two  <= port_address_high[7] && !port_mode_field[1] ? 1'b0 :
				port_address_high[7] && (chip_select_config_field == 2'b10 ||
				chip_select_config_field == 2'b01);
			port_out.cs_one  <= port_address_high[6] && port_mode_field[1] &&
				chip_select_config_field == 2'b10;
			port_out.alt_map <= ctrl_q[pport_pkg::map_pos];
			port_out.irq     <= port_interrupt_flag;
		end
	end

	// ==========================================
	// APB read mux; a zero-wait-state answer for every access
	always_comb begin
		rd_mux = 32'h0;
		known  = 1'b1;
		case (paddr)
			pport_pkg::ctrl_addr:    rd_mux = {24'h0, ctrl_q};
			pport_pkg::mode_addr:    rd_mux = {24'h0, mode_q};
			pport_pkg::addr_hi_addr: rd_mux = {24'h0, port_address_high};
			pport_pkg::addr_lo_addr: rd_mux = {24'h0, port_address_low};
			pport_pkg::out2_addr:    rd_mux = {16'h0, output_pair2_high, output_pair2_low};
			pport_pkg::in1_addr:     rd_mux = {16'h0, in_buf_q[1], in_buf_q[0]};
			pport_pkg::in2_addr:     rd_mux = {16'h0, in_buf_q[3], in_buf_q[2]};
			pport_pkg::stat_addr:    rd_mux = {16'h0, &input_buffer_full_flag,
				input_overflow_flag, 2'h0, input_buffer_full_flag,
				&output_buffer_empty_flag, output_underflow_flag,
				2'h0, output_buffer_empty_flag};
			pport_pkg::flag_addr:    rd_mux = {30'h0, wr_ptr_q == rd_ptr_q, port_interrupt_flag};
			default:                 known = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !known;
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
		end
	end
	wire logic unused_ok = setup_wr;
endmodule : parallel_port_unit

// ==== design/pport_pkg.sv ====
// How it works
// - Shared pair: address in master, output in slave
// - Input pair one always used; pair two buffered
// - Output pair two used only when buffered
// - High address bit 7 is chip select two
// - High address bit 6 is chip select one
// - High address bits 5..0 are address 13..8; code drives no address pins
// - Enhanced slave: high address is output byte; code answers host strobes only in legacy mode
// - Config bit selects alternate pin map
// - Legacy slave mode answers asynchronous host strobes
// - Legacy write captures byte, sets flags
// - Legacy read drives low output byte
// - Polarity bits set control input levels
// - Increment mode 11 enables four-deep buffering
// - Buffers numbered 0..3 low pair first
// - Read pointer steps buffer 0 to 3
// - Output empty flag set after host read
// - Read of empty buffer sets underflow
// - All outputs empty sets aggregate empty
// - Write pointer steps buffer 0 to 3
// - Input full set by write, cleared by read
// - Write to full buffer sets overflow; code sets it only in buffered mode
// - All inputs full sets aggregate full
// - Interrupt mode 01 every strobe, 11 fourth
// - Overflow and underflow cleared only by software
// - Software write clears output empty; resets empty
// - Mode field: 00 legacy, 01 addressable, 1x master
package pport_pkg;
	// ==========================================
	// Register byte addresses
	localparam logic [7:0] ctrl_addr     = 8'h00;
	localparam logic [7:0] mode_addr     = 8'h04;
	localparam logic [7:0] addr_hi_addr  = 8'h08;
	localparam logic [7:0] addr_lo_addr  = 8'h0c;
	localparam logic [7:0] out2_addr     = 8'h10;
	localparam logic [7:0] in1_addr      = 8'h14;
	localparam logic [7:0] in2_addr      = 8'h18;
	localparam logic [7:0] stat_addr     = 8'h1c;
	localparam logic [7:0] flag_addr     = 8'h20;
	// ==========================================
	// Control register fields
	localparam int en_pos    = 7;
	localparam int csp_pos   = 2;
	localparam int wrp_pos   = 1;
	localparam int rdp_pos   = 0;
	localparam int map_pos   = 3;
	localparam int cscf_pos  = 5;
	// Mode register fields
	localparam int mode_pos  = 0;
	localparam int incm_pos  = 3;
	localparam int irqm_pos  = 5;
	// Status register fields
	localparam int ovf_pos   = 14;
	localparam int unf_pos   = 6;
	localparam logic [1:0] mode_legacy = 2'h0;
	localparam logic [1:0] incm_buf    = 2'h3;
	localparam logic [1:0] irq_every   = 2'h1;
	localparam logic [1:0] irq_fourth  = 2'h3;
	localparam logic [3:0] obe_reset   = 4'hf;

	typedef enum logic [1:0] {
		mode_legacy_slave = 2'b00,
		mode_addr_slave   = 2'b01,
		mode_master_two   = 2'b10,
		mode_master_one   = 2'b11
	} port_mode_type;

	typedef struct packed {
		logic       cs;
		logic       rd;
		logic       wr;
		logic [7:0] data;
	} host_pins_type;

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] data_oe;
		logic       cs_one;
		logic       cs_two;
		logic       alt_map;
		logic       irq;
	} port_out_type;
endpackage : pport_pkg

// ==== tb/host_model.sv ====
`timescale 1ns/1ns
module host_model (
	input  wire logic                    core_clk,
	input  wire logic                    act_high,
	input  wire pport_pkg::port_out_type port_out,
	output pport_pkg::host_pins_type     host_in
);
	logic       cs, rd, wr;
	logic [7:0] d;
	initial {cs, rd, wr, d} = 11'h000;
	// Released lines show the inverse of the last byte, so stale data never matches
	assign host_in = {cs ~^ act_high, rd ~^ act_high, wr ~^ act_high,
		wr ? d : (port_out.data & port_out.data_oe) | (~d & ~port_out.data_oe)};
	// Strobes held 5 cycles and idle 6, longer than the device needs to sync
	task automatic send(input logic [7:0] v);
		@(posedge core_clk);
		{cs, wr, d} <= {2'b11, v};
		repeat (5) @(posedge core_clk);
		{cs, wr} <= 2'b00;
		repeat (6) @(posedge core_clk);
	endtask : send
	task automatic fetch(output logic [7:0] v);
		@(posedge core_clk);
		{cs, rd} <= 2'b11;
		repeat (5) @(posedge core_clk);
		v = host_in.data;
		{cs, rd} <= 2'b00;
		repeat (6) @(posedge core_clk);
	endtask : fetch
endmodule : host_model

// ==== tb/port_unit_properties.sv ====
`timescale 1ns/1ns
module port_unit_checker (
	input wire logic                     core_clk,
	input wire logic                     srst,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [7:0]               paddr,
	input wire logic [31:0]              pwdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire pport_pkg::host_pins_type host_in,
	input wire pport_pkg::port_out_type  port_out
);
	logic [7:0] ctrl_q, mode_q, ahi_q;
	logic [4:0] rd_hist_q;
	logic       wr_go, rd_sel, lg_wr;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// ==========================================
	// Shadow of the registers that steer the pins
	assign wr_go = psel && penable && pready && pwrite;
	always_ff @(posedge core_clk) begin
		if (srst)
			{ctrl_q, mode_q, ahi_q} <= 24'h000000;
		else if (wr_go && paddr == pport_pkg::ctrl_addr)
			ctrl_q <= pwdata[7:0];
		else if (wr_go && paddr == pport_pkg::mode_addr)
			mode_q <= pwdata[7:0];
		else if (wr_go && paddr == pport_pkg::addr_hi_addr)
			ahi_q <= pwdata[7:0];
	end
	// Strobes are judged in the polarity software chose
	assign rd_sel = ctrl_q[7] && mode_q[1:0] == 2'h0 && (host_in.cs ~^ ctrl_q[2])
		&& (host_in.rd ~^ ctrl_q[0]);
	assign lg_wr = ctrl_q[7] && mode_q[4:0] == 5'h00 && (host_in.cs ~^ ctrl_q[2])
		&& (host_in.wr ~^ ctrl_q[1]);
	// Drive may trail the strobe by the sync lag, so remember a few cycles
	always_ff @(posedge core_clk) begin
		rd_hist_q <= srst ? 5'h00 : {rd_hist_q[3:0], rd_sel};
	end
	// ==========================================
	// Properties
	sequence s_wr_held; lg_wr [*4]; endsequence
	sequence s_wr_done; !lg_wr [*6]; endsequence
	property p_ready_after_setup; psel && !penable |=> pready; endproperty
	property p_unmapped_err;
		psel && !penable && (paddr > 8'h20 || paddr[1:0] != 2'h0) |=> pready && pslverr;
	endproperty
	property p_oe_on_read; rd_sel [*4] |=> port_out.data_oe == 8'hff; endproperty
	property p_oe_needs_read; port_out.data_oe != 8'h00 |-> rd_hist_q != 5'h00; endproperty
	property p_cs_two;
		(ctrl_q[7] && mode_q[1] && ctrl_q[6] != ctrl_q[5] && ahi_q[7]) [*3] |-> port_out.cs_two;
	endproperty
	property p_cs_one;
		(ctrl_q[7] && mode_q[1] && ctrl_q[6:5] == 2'h2 && ahi_q[6]) [*3] |-> port_out.cs_one;
	endproperty
	property p_alt_map; $stable(ctrl_q[3]) [*3] |-> port_out.alt_map == ctrl_q[3]; endproperty
	property p_irq_legacy_write; s_wr_held ##1 s_wr_done |-> port_out.irq; endproperty
	a_ready_after_setup: assert property (p_ready_after_setup)
		else $error("no pready after setup");
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("no slave error on unmapped address");
	a_oe_on_read: assert property (p_oe_on_read)
		else $error("data not driven during read");
	a_oe_needs_read: assert property (p_oe_needs_read)
		else $error("data driven without read");
	a_cs_two: assert property (p_cs_two)
		else $error("second chip select not active");
	a_cs_one: assert property (p_cs_one)
		else $error("first chip select not active");
	a_alt_map: assert property (p_alt_map)
		else $error("pin map output differs from its bit");
	a_irq_legacy_write: assert property (p_irq_legacy_write)
		else $error("no interrupt after host write");
endmodule : port_unit_checker

bind parallel_port_unit port_unit_checker u_chk (.core_clk(core_clk), .srst(srst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .host_in(host_in), .port_out(port_out));

// ==== tb/tb_parallel_port_unit.sv ====
`timescale 1ns/1ns
module tb_parallel_port_unit;
	logic                     core_clk, srst, psel, penable, pwrite, pready, pslverr, perr;
	logic                     act_high;
	logic [7:0]               paddr, b;
	logic [31:0]              pwdata, prdata, rd;
	int                       error_cnt, n_compared;
	pport_pkg::host_pins_type host_in;
	pport_pkg::port_out_type  port_out;
	parallel_port_unit uut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .host_in(host_in), .port_out(port_out));
	host_model host (.core_clk(core_clk), .act_high(act_high), .port_out(port_out),
		.host_in(host_in));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ==========================================
	// Tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			error_cnt++;
		rd = prdata;
		perr = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic reg_is(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk($sformatf("register %h", a), rd, exp);
	endtask : reg_is
	task automatic stop_test;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	initial begin
		#100000;
		error_cnt++;
		stop_test();
	end
	// ==========================================
	// Tests
	initial begin
		{srst, psel, penable, pwrite, paddr, pwdata, act_high} = {4'h8, 8'h00, 32'h0, 1'b0};
		error_cnt = 0;
		n_compared = 0;
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		reg_is(pport_pkg::stat_addr, 32'h8f);
		reg_is(8'h40, 32'h0);
		chk("slave error", perr, 1'b1);
		// Legacy slave with active-low strobes
		apb(1'b1, pport_pkg::ctrl_addr, 32'h80);
		host.send(8'ha5);
		chk("interrupt", port_out.irq, 1'b1);
		reg_is(pport_pkg::in1_addr, 32'ha5);
		apb(1'b1, pport_pkg::addr_lo_addr, 32'h3c);
		host.fetch(b);
		chk("host byte", b, 8'h3c);
		reg_is(pport_pkg::stat_addr, 32'h8f);
		// Buffered slave, active-high strobes, interrupt on every strobe
		apb(1'b1, pport_pkg::ctrl_addr, 32'h0);
		act_high <= 1'b1;
		apb(1'b1, pport_pkg::mode_addr, 32'h38);
		apb(1'b1, pport_pkg::ctrl_addr, 32'h87);
		apb(1'b1, pport_pkg::addr_lo_addr, 32'h11);
		apb(1'b1, pport_pkg::addr_hi_addr, 32'h22);
		apb(1'b1, pport_pkg::out2_addr, 32'h4433);
		reg_is(pport_pkg::stat_addr, 32'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, pport_pkg::flag_addr, 32'h1);
			host.fetch(b);
			chk("host byte", b, 8'h11 * (i + 1));
			reg_is(pport_pkg::flag_addr, {30'h0, i == 3, 1'b1});
			reg_is(pport_pkg::stat_addr, ((32'h1 << (i + 1)) - 1) | (i == 3 ? 32'h80 : 0));
		end
		host.fetch(b);
		reg_is(pport_pkg::stat_addr, 32'hcf);
		reg_is(pport_pkg::stat_addr, 32'hcf);
		apb(1'b1, pport_pkg::stat_addr, 32'h40);
		for (int i = 0; i < 4; i++) begin
			host.send(8'ha0 + 8'(i));
			reg_is(pport_pkg::stat_addr, 32'h8f | (((32'h1 << (i + 1)) - 1) << 8)
				| (i == 3 ? 32'h8000 : 0));
		end
		host.send(8'hee);
		reg_is(pport_pkg::stat_addr, 32'hcf8f);
		reg_is(pport_pkg::in1_addr, 32'ha1a0);
		reg_is(pport_pkg::in2_addr, 32'ha3a2);
		reg_is(pport_pkg::stat_addr, 32'h408f);
		// Re-enable clears the pointers; interrupt only on the fourth write
		apb(1'b1, pport_pkg::ctrl_addr, 32'h0);
		apb(1'b1, pport_pkg::mode_addr, 32'h78);
		apb(1'b1, pport_pkg::flag_addr, 32'h1);
		apb(1'b1, pport_pkg::ctrl_addr, 32'h87);
		for (int i = 0; i < 4; i++) begin
			host.send(8'(i));
			apb(1'b0, pport_pkg::flag_addr, 32'h0);
			chk("interrupt", rd[0], i == 3);
		end
		// Master mode: chip selects and pin map
		apb(1'b1, pport_pkg::mode_addr, 32'h2);
		apb(1'b1, pport_pkg::ctrl_addr, 32'hc8);
		apb(1'b1, pport_pkg::addr_hi_addr, 32'hc5);
		reg_is(pport_pkg::addr_hi_addr, 32'hc5);
		chk("pins", {port_out.cs_one, port_out.cs_two, port_out.alt_map}, 3'h7);
		apb(1'b1, pport_pkg::ctrl_addr, 32'ha0);
		repeat (3) @(posedge core_clk);
		chk("pins", {port_out.cs_one, port_out.cs_two, port_out.alt_map}, 3'h2);
		stop_test();
	end
endmodule : tb_parallel_port_unit
